// file: rtl/osc_pkg.sv
// Package: register map, field layout, reset values and timing of the
// oscillator controller.
// Assumes an APB slave clocked by MCLK at 40 MHz with a synchronous reset.
package osc_pkg;

    localparam int MCLK_KHZ = 40000;

    localparam logic [7:0] OFS_MAIN = 8'h00;
    localparam logic [7:0] OFS_SLOW = 8'h04;
    localparam logic [7:0] OFS_PLL = 8'h08;
    localparam logic [7:0] OFS_RATIO = 8'h0C;
    localparam logic [7:0] OFS_FLL = 8'h10;
    localparam logic [7:0] OFS_FSYNC = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IEN_SET = 8'h1C;
    localparam logic [7:0] OFS_IEN_CLR = 8'h20;
    localparam logic [7:0] OFS_FLAG = 8'h24;

    localparam int MAIN_EN_BIT = 0;
    localparam int MAIN_OND_BIT = 1;
    localparam int MAIN_KEEP_BIT = 2;
    localparam int MAIN_SEL_LSB = 4;
    localparam int SLOW_EN_BIT = 0;
    localparam int SLOW_XTAL_BIT = 1;
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_REF_LSB = 1;
    localparam int PLL_LT_LSB = 8;
    localparam int RATIO_INT_LSB = 0;
    localparam int RATIO_FRAC_LSB = 16;
    localparam int FLL_EN_BIT = 0;
    localparam int FLL_VAL_LSB = 8;
    localparam int FLL_RREQ_BIT = 0;

    localparam int NFLAG = 12;
    localparam int F_MAIN_RDY = 0;
    localparam int F_FLL_RDY = 1;
    localparam int F_FLL_STOP = 2;
    localparam int F_IO_DET = 4;
    localparam int F_CORE_SRDY = 8;
    localparam int F_LOCK = 9;
    localparam int F_LOCK_LOST = 10;
    localparam int F_LOCK_TO = 11;

    localparam logic [31:0] RST_REG = 32'h0000_0000;

    localparam int FLL_SYNC_NS = 150;
    localparam int FLL_SYNC_CYC = (FLL_SYNC_NS * MCLK_KHZ + 999999) / 1000000;
    localparam logic [2:0] FSYNC_LOAD = 3'(FLL_SYNC_CYC);
    localparam int RELOCK_NS = 100;
    localparam int RELOCK_CYC = (RELOCK_NS * MCLK_KHZ + 999999) / 1000000;
    localparam logic [2:0] RELOCK_LOAD = 3'(RELOCK_CYC);
    localparam int LT_UNIT_NS = 1000;
    localparam logic [13:0] LT_UNIT = 14'(LT_UNIT_NS * MCLK_KHZ / 1000000);

    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_RESP = 2'b01,
        A_STALL = 2'b10
    } osc_apb_e;

endpackage

// file: rtl/osc_system_controller.sv
// Oscillator, PLL and loop controller with its APB register file.
// Assumes analog status inputs are asynchronous; sleep and request inputs
// come from logic on MCLK.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module osc_system_controller import osc_pkg::*; #(
    parameter logic [15:0] SETTLE_UNIT = 16'h0001
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Sleep state and clock requests
    input wire logic SLEEP_STANDBY,
    input wire logic OSC_REQ,
    // Analog status
    input wire logic FLL_REF_STOP,
    input wire logic IO_BO_RDY,
    input wire logic IO_BO_DET,
    input wire logic IO_BO_SRDY,
    input wire logic CORE_BO_RDY,
    input wire logic CORE_BO_DET,
    input wire logic CORE_BO_SRDY,
    input wire logic PLL_LOCK_IN,
    // Main oscillator
    output logic MAIN_OSC_EN,
    output logic MAIN_OSC_OUT_EN,
    // Slow oscillator
    output logic SLOW_OSC_EN,
    output logic SLOW_XTAL_MODE,
    output logic SLOW_IN_PIN_OWN,
    output logic SLOW_OUT_PIN_OWN,
    // PLL
    output logic PLL_EN,
    output logic [1:0] PLL_REF_SEL,
    output logic [11:0] PLL_RATIO_INT,
    output logic [3:0] PLL_RATIO_FRAC,
    // Loop
    output logic FLL_EN,
    output logic [7:0] FLL_VALUE,
    // Requests
    output logic IRQ,
    output logic IO_BO_WAKE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        osc_apb_e ast;
        logic pready;
        logic perr;
        logic [31:0] prdata;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic main_en;
        logic main_ond;
        logic main_keep;
        logic [3:0] main_sel;
        logic main_run;
        logic [15:0] settle_cnt;
        logic main_rdy;
        logic slow_en;
        logic slow_xtal;
        logic slow_out_own;
        logic pll_en;
        logic [1:0] pll_ref;
        logic [7:0] pll_lt;
        logic [11:0] pll_int;
        logic [3:0] pll_frac;
        logic [2:0] relock_cnt;
        logic pll_lock;
        logic [13:0] lt_cnt;
        logic lt_done;
        logic fll_en;
        logic [7:0] fll_val;
        logic [2:0] fsync_cnt;
        logic rd_synced;
        logic [NFLAG-1:0] sts_prev;
        logic [NFLAG-1:0] flag;
        logic [NFLAG-1:0] ien;
        logic irq;
        logic wake;
    } osc_state_s;

    osc_state_s st;
    osc_state_s next_st;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        return a inside {OFS_MAIN, OFS_SLOW, OFS_PLL, OFS_RATIO, OFS_FLL,
                         OFS_FSYNC, OFS_STATUS, OFS_IEN_SET, OFS_IEN_CLR, OFS_FLAG};
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a, input osc_state_s s,
                                            input logic [NFLAG-1:0] sts);
        logic [31:0] w;
        w = RST_REG;
        case (a)
            OFS_MAIN: begin
                w[MAIN_EN_BIT] = s.main_en;
                w[MAIN_OND_BIT] = s.main_ond;
                w[MAIN_KEEP_BIT] = s.main_keep;
                w[MAIN_SEL_LSB +: 4] = s.main_sel;
            end
            OFS_SLOW: begin
                w[SLOW_EN_BIT] = s.slow_en;
                w[SLOW_XTAL_BIT] = s.slow_xtal;
            end
            OFS_PLL: begin
                w[PLL_EN_BIT] = s.pll_en;
                w[PLL_REF_LSB +: 2] = s.pll_ref;
                w[PLL_LT_LSB +: 8] = s.pll_lt;
            end
            OFS_RATIO: begin
                w[RATIO_INT_LSB +: 12] = s.pll_int;
                w[RATIO_FRAC_LSB +: 4] = s.pll_frac;
            end
            OFS_FLL: begin
                w[FLL_EN_BIT] = s.fll_en;
                w[FLL_VAL_LSB +: 8] = s.fll_val;
            end
            OFS_STATUS: w[NFLAG-1:0] = sts;
            OFS_IEN_SET: w[NFLAG-1:0] = s.ien;
            OFS_IEN_CLR: w[NFLAG-1:0] = s.ien;
            OFS_FLAG: w[NFLAG-1:0] = s.flag;
            default: w = RST_REG;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [NFLAG-1:0] cur;
        logic [NFLAG-1:0] set;
        logic [NFLAG-1:0] clr;
        logic [31:0] wd;
        logic wr_hit;
        cur = '0;
        set = '0;
        clr = '0;
        wd = PWDATA;
        wr_hit = 1'b0;
        next_st = st;

        // Two-flop synchronisers for analog status
        next_st.sync1 = {PLL_LOCK_IN, CORE_BO_SRDY, CORE_BO_DET, CORE_BO_RDY,
                         IO_BO_SRDY, IO_BO_DET, IO_BO_RDY, FLL_REF_STOP};
        next_st.sync2 = st.sync1;

        // Status vector
        cur[F_MAIN_RDY] = st.main_rdy;
        cur[F_FLL_RDY] = (st.fsync_cnt == 3'd0);
        cur[F_CORE_SRDY:F_FLL_STOP] = st.sync2[6:0];
        cur[F_LOCK] = st.pll_lock;
        set = cur & ~st.sts_prev;

        // Counters
        if (st.fsync_cnt != 3'd0) begin
            next_st.fsync_cnt = st.fsync_cnt - 3'd1;
        end
        if (st.relock_cnt != 3'd0) begin
            next_st.relock_cnt = st.relock_cnt - 3'd1;
        end

        // APB handshake
        case (st.ast)
            A_IDLE: begin
                next_st.pready = 1'b0;
                if (PSEL && !PENABLE) begin
                    if (!PWRITE && PADDR == OFS_FLL && st.fll_en && !st.rd_synced) begin
                        next_st.ast = A_STALL;
                        if (st.fsync_cnt == 3'd0) begin
                            next_st.fsync_cnt = FSYNC_LOAD;
                        end
                    end else begin
                        next_st.ast = A_RESP;
                        next_st.pready = 1'b1;
                        next_st.perr = !mapped(PADDR);
                        next_st.prdata = rd_word(PADDR, st, cur);
                    end
                end
            end
            A_RESP: begin
                next_st.ast = A_IDLE;
                next_st.pready = 1'b0;
                next_st.perr = 1'b0;
                if (!PWRITE && PADDR == OFS_FLL) begin
                    next_st.rd_synced = 1'b0;
                end
            end
            A_STALL: begin
                if (st.fsync_cnt == 3'd0) begin
                    next_st.ast = A_RESP;
                    next_st.pready = 1'b1;
                    next_st.perr = 1'b0;
                    next_st.prdata = rd_word(PADDR, st, cur);
                end
            end
            default: begin
                next_st.ast = A_IDLE;
                next_st.pready = 1'b0;
            end
        endcase

        // Register writes, taken at the edge that completes the access
        wr_hit = (st.ast == A_RESP) && PSEL && PENABLE && PWRITE && !st.perr;
        if (wr_hit) begin
            case (PADDR)
                OFS_MAIN: begin
                    next_st.main_en = wd[MAIN_EN_BIT];
                    next_st.main_ond = wd[MAIN_OND_BIT];
                    next_st.main_keep = wd[MAIN_KEEP_BIT];
                    next_st.main_sel = wd[MAIN_SEL_LSB +: 4];
                end
                OFS_SLOW: begin
                    next_st.slow_en = wd[SLOW_EN_BIT];
                    next_st.slow_xtal = wd[SLOW_XTAL_BIT];
                end
                OFS_PLL: begin
                    next_st.pll_en = wd[PLL_EN_BIT];
                    next_st.pll_ref = wd[PLL_REF_LSB +: 2];
                    next_st.pll_lt = wd[PLL_LT_LSB +: 8];
                end
                OFS_RATIO: begin
                    next_st.pll_int = wd[RATIO_INT_LSB +: 12];
                    next_st.pll_frac = wd[RATIO_FRAC_LSB +: 4];
                    if (st.pll_en) begin
                        next_st.relock_cnt = RELOCK_LOAD;
                    end
                end
                OFS_FLL: begin
                    if (st.fsync_cnt == 3'd0) begin
                        next_st.fll_en = wd[FLL_EN_BIT];
                        next_st.fll_val = wd[FLL_VAL_LSB +: 8];
                        next_st.fsync_cnt = FSYNC_LOAD;
                    end
                end
                OFS_FSYNC: begin
                    if (wd[FLL_RREQ_BIT]) begin
                        next_st.fsync_cnt = FSYNC_LOAD;
                        next_st.rd_synced = 1'b1;
                    end
                end
                OFS_IEN_SET: next_st.ien = st.ien | wd[NFLAG-1:0];
                OFS_IEN_CLR: next_st.ien = st.ien & ~wd[NFLAG-1:0];
                OFS_FLAG: clr = wd[NFLAG-1:0];
                default: begin
                end
            endcase
        end

        // Main oscillator gating and start-up masking
        next_st.main_run = st.main_en && (!SLEEP_STANDBY || st.main_keep)
                           && (!st.main_ond || OSC_REQ);
        if (!st.main_run) begin
            next_st.settle_cnt = 16'(SETTLE_UNIT << st.main_sel);
            next_st.main_rdy = 1'b0;
        end else if (st.settle_cnt != 16'd0) begin
            next_st.settle_cnt = st.settle_cnt - 16'd1;
            next_st.main_rdy = (st.settle_cnt == 16'd1);
        end

        // Slow oscillator pin takeover
        next_st.slow_out_own = next_st.slow_en && next_st.slow_xtal;

        // PLL lock and lock timer
        next_st.pll_lock = next_st.pll_en && st.sync2[7] && (next_st.relock_cnt == 3'd0);
        if (!st.pll_en) begin
            next_st.lt_cnt = 14'd0;
            next_st.lt_done = 1'b0;
        end else if (!st.lt_done) begin
            next_st.lt_cnt = st.lt_cnt + 14'd1;
            if (st.pll_lock) begin
                next_st.lt_done = 1'b1;
            end else if (st.pll_lt != 8'd0 && st.lt_cnt == 14'(14'(st.pll_lt) * LT_UNIT)) begin
                next_st.lt_done = 1'b1;
                set[F_LOCK_TO] = 1'b1;
            end
        end
        set[F_LOCK_LOST] = st.sts_prev[F_LOCK] && !cur[F_LOCK] && st.pll_en
                           && (st.relock_cnt == 3'd0);

        // Flags, enables and request line; a new event wins over its clear
        next_st.sts_prev = cur;
        next_st.flag = (st.flag & ~clr) | set;
        next_st.irq = |(next_st.flag & next_st.ien);
        next_st.wake = next_st.flag[F_IO_DET] && next_st.ien[F_IO_DET];
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA = st.prdata;
    assign PREADY = st.pready;
    assign PSLVERR = st.perr;
    assign MAIN_OSC_EN = st.main_run;
    assign MAIN_OSC_OUT_EN = st.main_rdy;
    assign SLOW_OSC_EN = st.slow_en;
    assign SLOW_XTAL_MODE = st.slow_xtal;
    assign SLOW_IN_PIN_OWN = st.slow_en;
    assign SLOW_OUT_PIN_OWN = st.slow_out_own;
    assign PLL_EN = st.pll_en;
    assign PLL_REF_SEL = st.pll_ref;
    assign PLL_RATIO_INT = st.pll_int;
    assign PLL_RATIO_FRAC = st.pll_frac;
    assign FLL_EN = st.fll_en;
    assign FLL_VALUE = st.fll_val;
    assign IRQ = st.irq;
    assign IO_BO_WAKE = st.wake;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence s_wr(logic [7:0] o);
        st.ast == A_RESP && PSEL && PENABLE && PWRITE && PADDR == o;
    endsequence

    sequence s_stall_rd;
        st.ast == A_IDLE && PSEL && !PENABLE && !PWRITE && PADDR == OFS_FLL
        && st.fll_en && !st.rd_synced && st.fsync_cnt == 3'd0;
    endsequence

    a_main_off: assert property (!st.main_en |=> !MAIN_OSC_EN)
        else $error("main oscillator runs while disabled");
    a_main_demand: assert property (st.main_ond && !OSC_REQ |=> !MAIN_OSC_EN)
        else $error("main oscillator runs without request");
    a_settle_mask: assert property ($rose(MAIN_OSC_EN) |-> !MAIN_OSC_OUT_EN)
        else $error("main oscillator output not masked at start");
    a_ready_time: assert property ($rose(MAIN_OSC_OUT_EN) |-> $past(st.settle_cnt) == 16'd1)
        else $error("main ready before settle time");
    a_ready_flag: assert property ($rose(st.main_rdy) |=> ##1 st.flag[F_MAIN_RDY])
        else $error("main ready flag missing");
    a_slow_out_pin: assert property (SLOW_OUT_PIN_OWN == (SLOW_OSC_EN && SLOW_XTAL_MODE))
        else $error("slow output pin ownership wrong");
    a_relock_hide: assert property (s_wr(OFS_RATIO) ##0 st.pll_en |=> !st.pll_lock [*4])
        else $error("lock not cleared on ratio update");
    a_det_flag: assert property ($rose(st.sync2[2]) |=> st.flag[F_IO_DET])
        else $error("io brown-out detect flag missing");
    a_irq_or: assert property (IRQ == |(st.flag & st.ien))
        else $error("interrupt line disagrees with flags");
    a_ien_set: assert property (s_wr(OFS_IEN_SET) |=> (st.ien & $past(PWDATA[NFLAG-1:0]))
                                == $past(PWDATA[NFLAG-1:0]))
        else $error("enable set write lost");
    a_fll_locked: assert property (s_wr(OFS_FLL) ##0 st.fsync_cnt != 3'd0 |=> $stable(FLL_VALUE))
        else $error("loop write taken while not ready");
    a_stall_read: assert property (s_stall_rd |=> !PREADY [*7] ##1 PREADY)
        else $error("loop read stall length wrong");

endmodule // osc_system_controller

// file: test/osc_system_controller_bench.sv
// Self-checking bench for the oscillator controller: APB master tasks, expected values and scenarios.
// Assumes osc_pkg and osc_system_controller are compiled first; checkers sit inside the design.
`timescale 1ns/1ps

module osc_system_controller_bench import osc_pkg::*;;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, standby = 0, req = 0, err;
    logic [7:0] paddr = 8'h00, st = 8'h00, v1;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v, d, m [0:9];
    logic pready, pslverr, main_en, main_out, slow_en, slow_x, in_own, out_own, pll_en, fll_en, irq, wake;
    logic [1:0] ref_sel;
    logic [11:0] r_int;
    logic [3:0] r_frac;
    logic [7:0] fll_val;
    int bad_count = 0, cmp_count = 0, seed = 32'h8c7a, waits, n, i;

    osc_system_controller #(.SETTLE_UNIT(16'h0001)) dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SLEEP_STANDBY(standby), .OSC_REQ(req), .FLL_REF_STOP(st[0]), .IO_BO_RDY(st[1]), .IO_BO_DET(st[2]),
        .IO_BO_SRDY(st[3]), .CORE_BO_RDY(st[4]), .CORE_BO_DET(st[5]), .CORE_BO_SRDY(st[6]),
        .PLL_LOCK_IN(st[7]), .MAIN_OSC_EN(main_en), .MAIN_OSC_OUT_EN(main_out), .SLOW_OSC_EN(slow_en),
        .SLOW_XTAL_MODE(slow_x), .SLOW_IN_PIN_OWN(in_own), .SLOW_OUT_PIN_OWN(out_own), .PLL_EN(pll_en),
        .PLL_REF_SEL(ref_sel), .PLL_RATIO_INT(r_int), .PLL_RATIO_FRAC(r_frac), .FLL_EN(fll_en),
        .FLL_VALUE(fll_val), .IRQ(irq), .IO_BO_WAKE(wake));

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        waits = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && waits < 100) begin
            waits++;
            @(posedge mclk);
        end
        if (waits >= 100) bad_count++;
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    function automatic logic [31:0] msk(input logic [7:0] a);
        case (a)
            OFS_MAIN: return 32'h0000_00F7;
            OFS_SLOW: return 32'h0000_0003;
            OFS_PLL: return 32'h0000_FF07;
            OFS_RATIO: return 32'h000F_0FFF;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        m[a[5:2]] = wd & msk(a);
    endtask

    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    task settle(output int c);
        c = 0;
        while (main_out !== 1'b1 && c < 100) begin
            @(posedge mclk);
            c++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        foreach (m[k]) m[k] = RST_REG;
        tick(5);
        rst <= 0;
        tick(3);
        chk("slow_off", 3'b000, {slow_en, in_own, out_own});
        rdc("main_rst", OFS_MAIN, m[0]);
        rdc("slow_rst", OFS_SLOW, m[1]);
        apb(1'b0, 8'h28, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], err});
        for (i = 0; i < 4; i++) begin
            wr(OFS_SLOW, 32'(i));
            tick(2);
            chk("slow_pins", {i[0], i[1], i[0], i[0] & i[1]}, {slow_en, slow_x, in_own, out_own});
            rdc("slow_reg", OFS_SLOW, m[1]);
        end
        wr(OFS_SLOW, 32'h0000_0002);
        tick(2);
        chk("slow_stop", 4'b0100, {slow_en, slow_x, in_own, out_own});
        for (i = 0; i < 32; i++) begin
            standby <= i[3]; req <= i[4];
            wr(OFS_MAIN, 32'(i[2:0]));
            tick(3);
            chk("main_run", i[0] & (i[3] ? i[2] : 1'b1) & (i[1] ? i[4] : 1'b1), main_en);
        end
        standby <= 0; req <= 0;
        wr(OFS_MAIN, 32'h0000_0000);
        apb(1'b1, OFS_FLAG, 32'h0000_0FFF);
        apb(1'b1, OFS_IEN_SET, 32'h0000_0001);
        wr(OFS_MAIN, 32'h0000_0031);
        chk("masked", 0, main_out);
        settle(n);
        chk("settle", 1, 32'(n >= 8 && n <= 13));
        rdc("main_flag", OFS_FLAG, 32'h0000_0001);
        chk("main_irq", 1, irq);
        rdm_main: rdc("main_reg", OFS_MAIN, m[0]);
        standby <= 1;
        tick(5);
        chk("stopped", 2'b00, {main_en, main_out});
        standby <= 0;
        settle(n);
        chk("restart", 1, 32'(n >= 8 && n <= 13));
        wr(OFS_MAIN, 32'h0000_0000);
        apb(1'b1, OFS_IEN_CLR, 32'h0000_0FFF);
        apb(1'b1, OFS_IEN_SET, 32'h0000_01FC);
        for (i = 0; i < 3; i++) begin
            v = $random(seed);
            apb(1'b1, OFS_FLAG, 32'h0000_0FFF);
            st[6:0] <= v[6:0] | 7'h04;
            tick(8);
            rdc("ev_flags", OFS_FLAG, {23'h0, v[6:0] | 7'h04, 2'b00});
            chk("ev_irq", 2'b11, {irq, wake});
            apb(1'b1, OFS_IEN_CLR, 32'h0000_01FC);
            tick(2);
            chk("irq_dis", 0, irq);
            apb(1'b1, OFS_IEN_SET, 32'h0000_01FC);
            tick(2);
            chk("irq_en", 1, irq);
            apb(1'b1, OFS_FLAG, {23'h0, v[6:0] | 7'h04, 2'b00});
            tick(2);
            chk("irq_clr", 2'b00, {irq, wake});
            st <= 8'h00;
            tick(6);
        end
        rdc("ien", OFS_IEN_CLR, 32'h0000_01FC);
        apb(1'b1, OFS_IEN_CLR, 32'h0000_0FFF);
        apb(1'b1, OFS_FLAG, 32'h0000_0FFF);
        wr(OFS_PLL, 32'h0000_0205);
        tick(55);
        rdc("lt_early", OFS_FLAG, 32'h0000_0000);
        tick(30);
        rdc("lt_flag", OFS_FLAG, 32'h0000_0800);
        st[7] <= 1;
        tick(8);
        rdc("lock_flag", OFS_FLAG, 32'h0000_0A00);
        rdc("lock_sts", OFS_STATUS, 32'h0000_0202);
        apb(1'b1, OFS_FLAG, 32'h0000_0FFF);
        d = $random(seed);
        wr(OFS_RATIO, d);
        rdc("relock_low", OFS_STATUS, 32'h0000_0002);
        tick(10);
        rdc("relock", OFS_STATUS, 32'h0000_0202);
        chk("ratio_out", d & 32'h000F_0FFF, {12'h0, r_frac, 4'h0, r_int});
        rdc("ratio_reg", OFS_RATIO, m[3]);
        rdc("no_lost", OFS_FLAG, 32'h0000_0200);
        st[7] <= 0;
        tick(8);
        rdc("lost", OFS_FLAG, 32'h0000_0600);
        wr(OFS_PLL, 32'h0000_0000);
        wr(OFS_PLL, 32'h0000_0002);
        wr(OFS_PLL, 32'h0000_0003);
        tick(2);
        chk("ref_sw", 3'b011, {ref_sel, pll_en});
        rdc("pll_reg", OFS_PLL, m[2]);
        apb(1'b1, OFS_FLAG, 32'h0000_0FFF);
        apb(1'b1, OFS_IEN_SET, 32'h0000_0002);
        v1 = 8'($random(seed));
        apb(1'b1, OFS_FLL, {16'h0, v1, 8'h01});
        apb(1'b1, OFS_FLL, {16'h0, ~v1, 8'h01});
        tick(10);
        chk("fll_out", {v1, 1'b1}, {fll_val, fll_en});
        rdc("fll_flag", OFS_FLAG, 32'h0000_0002);
        chk("fll_irq", 1, irq);
        rdc("fll_stall", OFS_FLL, {16'h0, v1, 8'h01});
        chk("stalled", 1, 32'(waits > 0));
        apb(1'b1, OFS_FSYNC, 32'h0000_0001);
        tick(10);
        rdc("fll_sync", OFS_FLL, {16'h0, v1, 8'h01});
        chk("no_stall", 0, waits);
        apb(1'b1, OFS_FLL, {16'h0, v1, 8'h00});
        tick(10);
        rdc("fll_off", OFS_FLL, {16'h0, v1, 8'h00});
        chk("off_stall", 0, waits);
        summarize();
    end

    initial begin
        tick(20000);
        bad_count++;
        summarize();
    end
endmodule // osc_system_controller_bench
